// file: rtl/ssp_pkg.sv
package ssp_pkg;
	// Register indices; the byte address is four times the index.
	localparam int unsigned ADDR_W = 10;
	localparam logic [7:0] IDX_FLAGS = 8'h0C;
	localparam logic [7:0] IDX_BUF = 8'h13;
	localparam logic [7:0] IDX_CTRL = 8'h14;
	localparam logic [7:0] IDX_DIR = 8'h87;
	localparam logic [7:0] IDX_EN = 8'h8C;
	localparam logic [7:0] IDX_SADR = 8'h93;
	localparam logic [7:0] IDX_STAT = 8'h94;

	// Control register fields.
	localparam int unsigned CT_WRITE_COLLISION_FLAG = 7;
	localparam int unsigned CT_OV = 6;
	localparam int unsigned CT_EN = 5;
	localparam int unsigned CT_CKP = 4;

	// Status register fields.
	localparam int unsigned ST_SMP = 7;
	localparam int unsigned ST_CKE = 6;
	localparam int unsigned ST_DA = 5;
	localparam int unsigned ST_P = 4;
	localparam int unsigned ST_S = 3;
	localparam int unsigned ST_RW = 2;
	localparam int unsigned ST_UA = 1;
	localparam int unsigned ST_BF = 0;

	// Flag, enable and direction fields.
	localparam int unsigned FL_PORT = 3;
	localparam int unsigned DIR_SDO = 0;
	localparam int unsigned DIR_SCK = 1;
	localparam int unsigned DIR_SDA = 2;

	// Reset values.
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] BUF_RST = 8'h00;
	localparam logic [7:0] SADR_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h07;
	localparam logic FLAG_RST = 1'b0;
	localparam logic EN_RST = 1'b0;

	// Port mode field encodings.
	localparam logic [3:0] MODE_MST_DIV4 = 4'h0;
	localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
	localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
	localparam logic [3:0] MODE_MST_TMR = 4'h3;
	localparam logic [3:0] MODE_SLV_SS = 4'h4;
	localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
	localparam logic [3:0] MODE_I2C7 = 4'h6;
	localparam logic [3:0] MODE_I2C10 = 4'h7;
	localparam logic [3:0] MODE_I2C_FW = 4'hB;
	localparam logic [3:0] MODE_I2C7_SS = 4'hE;
	localparam logic [3:0] MODE_I2C10_SS = 4'hF;

	// Timing and counts, in system clock cycles and bits.
	localparam logic [5:0] HALF_DIV4 = 6'h02;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV64 = 6'h20;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] I2C_BITS = 4'h8;
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_RX = 3'b001,
		I_ACK = 3'b010,
		I_TX = 3'b011,
		I_TXACK = 3'b100
	} ssp_i2c_e;

	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction
endpackage

// file: rtl/ssp_sync.sv
`timescale 1ns/100ps
module ssp_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Asynchronous levels
	input wire logic [W-1:0] async_in,
	// Synchronised level and its previous value
	output logic [W-1:0] sync_out,
	output logic [W-1:0] prev_out
);
	logic [W-1:0] meta;

	// Only the second stage reads the first one.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			meta <= '0;
			sync_out <= '0;
			prev_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
			prev_out <= sync_out;
		end
	end
endmodule

// file: rtl/ssp_i2c_cond.sv
`timescale 1ns/100ps
module ssp_i2c_cond (
	// Synchronised clock and data, now and one cycle ago
	input wire logic scl_in,
	input wire logic scl_prev_in,
	input wire logic sda_in,
	input wire logic sda_prev_in,
	// Bus events, one cycle each
	output logic start_out,
	output logic stop_out,
	output logic rise_out,
	output logic fall_out
);
	// Data moving while the clock is high marks a start or a stop.
	assign start_out = scl_in & scl_prev_in & sda_prev_in & ~sda_in;
	assign stop_out = scl_in & scl_prev_in & ~sda_prev_in & sda_in;
	assign rise_out = scl_in & ~scl_prev_in;
	assign fall_out = ~scl_in & scl_prev_in;
endmodule

// file: rtl/ssp_top.sv
`timescale 1ns/100ps
// How it works
// [R1] Select-synchronous behaviour only in mode 04h.
// [R2] Select low: shift both ways, drive output.
// [R3] Select high: release serial output at once.
// [R4] Select high or disable clears bit counter.
// [R5] Software enables select control when edge set.
// [R6] Output pin as input: never transmit.
// [R7] Master in sleep freezes, then resumes.
// [R8] Slave shifts during sleep, flags each byte.
// [R9] Device reset disables port, aborts transfer.
// [R10] Standard modes map onto polarity and edge.
// [R11] Sample-phase bit picks input sample point.
// [R12] Two-wire slave plus start/stop interrupts.
// [R13] Standard-mode speed, 7 and 10-bit addressing.
// [R14] Enable bit five activates the port.
// [R15] Mode field picks five two-wire configurations.
// [R16] Two-wire pins open-drain when set inputs.
// [R17] Slave-transmitter overrides data pin with data.
// [R18] Auto acknowledge, then load receive buffer.
// [R19] Full or overflow: no ack, no load.
// [R20] Buffer read clears full; software clears overflow.
// [R21] Eight bits in: load buffer, set flags.
// [R22] Buffer write while busy sets collision flag.
// [R23] Modes 0100/0101 select slave, select on/off.
// [R24] Shift most significant bit first, eight bits.
module ssp_top (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Register port
	input wire logic [ssp_pkg::ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Serial clock pin, shared with the two-wire clock
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_out,
	// Serial input pin, shared with the two-wire data
	input wire logic sdi_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Serial output and slave select pins
	output logic sdo_out,
	output logic sdo_oe_out,
	input wire logic ss_n_in,
	// Power management
	input wire logic sleep_in,
	output logic wake_out
);
	logic [7:0] ctrl, next_ctrl;
	logic [7:0] stat, next_stat;
	logic [7:0] buf_q, next_buf;
	logic [7:0] sadr, next_sadr;
	logic [7:0] dir, next_dir;
	logic [7:0] rdata, next_rdata;
	logic flag, next_flag;
	logic flag_en, next_flag_en;
	logic [7:0] sr, next_sr;
	logic sdo_q, next_sdo;
	logic [3:0] cnt, next_cnt;
	logic mst_run, next_mst_run;
	logic [5:0] div, next_div;
	logic sck_int, next_sck;
	logic [4:0] edges, next_edges;
	logic pend, next_pend;
	ssp_pkg::ssp_i2c_e ist, next_ist;
	logic ack, next_ack;
	logic rw, next_rw;
	logic addr_ph, next_addr_ph;
	logic addr2, next_addr2;

	logic [2:0] syn, prv;
	logic start, stop, rise, fall;
	logic [3:0] mode;
	logic en, clock_polarity_bit, cke, sample_phase_bit;
	logic is_mst, is_slv, ss_ctl, slv_act, i2c_slv, i2c_ssi, ten;
	logic tick, m_edge, lead, trail, out_ev, samp_ev, take, busy;
	logic rx_bit, i2c_match;
	logic [5:0] half;

	ssp_sync #(
		.W(3)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.async_in({ss_n_in, sdi_in, sck_in}),
		.sync_out(syn),
		.prev_out(prv)
	);

	ssp_i2c_cond u_cond (
		.scl_in(syn[0]),
		.scl_prev_in(prv[0]),
		.sda_in(syn[1]),
		.sda_prev_in(prv[1]),
		.start_out(start),
		.stop_out(stop),
		.rise_out(rise),
		.fall_out(fall)
	);

	assign mode = ctrl[3:0];
	// [R14] Port enable bit.
	assign en = ctrl[ssp_pkg::CT_EN];
	assign clock_polarity_bit = ctrl[ssp_pkg::CT_CKP];
	assign cke = stat[ssp_pkg::ST_CKE];
	assign sample_phase_bit = stat[ssp_pkg::ST_SMP];
	assign rx_bit = syn[1];
	assign is_mst = en & (mode[3:2] == 2'b00);
	// [R23] Slave mode decode.
	assign is_slv = en & ((mode == ssp_pkg::MODE_SLV_SS)
		| (mode == ssp_pkg::MODE_SLV_NOSS));
	// [R1] Select only in 04h.
	assign ss_ctl = mode == ssp_pkg::MODE_SLV_SS;
	// [R2] Active while select low.
	assign slv_act = is_slv & ~(ss_ctl & syn[2]);
	// [R15] Two-wire mode decode.
	assign i2c_slv = en & ((mode == ssp_pkg::MODE_I2C7)
		| (mode == ssp_pkg::MODE_I2C10)
		| (mode == ssp_pkg::MODE_I2C7_SS)
		| (mode == ssp_pkg::MODE_I2C10_SS));
	assign i2c_ssi = en & ((mode == ssp_pkg::MODE_I2C_FW)
		| (mode == ssp_pkg::MODE_I2C7_SS)
		| (mode == ssp_pkg::MODE_I2C10_SS));
	assign ten = (mode == ssp_pkg::MODE_I2C10)
		| (mode == ssp_pkg::MODE_I2C10_SS);
	// [R13] Second address byte compares all eight bits.
	assign i2c_match = addr2 ? (sr == sadr) : (sr[7:1] == sadr[7:1]);

	always_comb begin
		case (mode)
		ssp_pkg::MODE_MST_DIV4: half = ssp_pkg::HALF_DIV4;
		ssp_pkg::MODE_MST_DIV16: half = ssp_pkg::HALF_DIV16;
		default: half = ssp_pkg::HALF_DIV64;
		endcase
	end

	// [R7] Master clock stops while asleep.
	assign tick = mst_run & ~sleep_in & (div == 6'h00);
	assign m_edge = tick & (edges != ssp_pkg::EDGES_PER_BYTE);
	// [R8] Slave edges come from the pin, asleep or not.
	assign lead = is_mst ? (m_edge & (sck_int == clock_polarity_bit))
		: (slv_act & (clock_polarity_bit ? fall : rise));
	assign trail = is_mst ? (m_edge & (sck_int != clock_polarity_bit))
		: (slv_act & (clock_polarity_bit ? rise : fall));
	// [R10] Edge bit set: output on trailing edge.
	assign out_ev = cke ? trail : lead;
	assign samp_ev = cke ? lead : trail;
	// [R11] Late sampling waits half a bit in master mode.
	assign take = (is_mst & sample_phase_bit) ? (pend & tick) : samp_ev;
	assign busy = mst_run | (cnt != 4'h0);

	always_comb begin
		next_ctrl = ctrl;
		next_stat = stat;
		next_buf = buf_q;
		next_sadr = sadr;
		next_dir = dir;
		next_flag = flag;
		next_flag_en = flag_en;
		next_rdata = 8'h00;
		next_sr = sr;
		next_sdo = sdo_q;
		next_cnt = cnt;
		next_mst_run = mst_run;
		next_div = div;
		next_sck = sck_int;
		next_edges = edges;
		next_pend = pend;
		next_ist = ist;
		next_ack = ack;
		next_rw = rw;
		next_addr_ph = addr_ph;
		next_addr2 = addr2;

		// Software accesses come first so that hardware sets win.
		if (rd_in) begin
			case (addr_in)
			ssp_pkg::reg_addr(ssp_pkg::IDX_FLAGS):
				next_rdata[ssp_pkg::FL_PORT] = flag;
			ssp_pkg::reg_addr(ssp_pkg::IDX_BUF): begin
				next_rdata = buf_q;
				// [R20] Read clears full.
				next_stat[ssp_pkg::ST_BF] = 1'b0;
			end
			ssp_pkg::reg_addr(ssp_pkg::IDX_CTRL): next_rdata = ctrl;
			ssp_pkg::reg_addr(ssp_pkg::IDX_DIR): next_rdata = dir;
			ssp_pkg::reg_addr(ssp_pkg::IDX_EN):
				next_rdata[ssp_pkg::FL_PORT] = flag_en;
			ssp_pkg::reg_addr(ssp_pkg::IDX_SADR): next_rdata = sadr;
			ssp_pkg::reg_addr(ssp_pkg::IDX_STAT): next_rdata = stat;
			default: next_rdata = 8'h00;
			endcase
		end
		if (wr_in) begin
			case (addr_in)
			ssp_pkg::reg_addr(ssp_pkg::IDX_FLAGS):
				next_flag = wdata_in[ssp_pkg::FL_PORT];
			ssp_pkg::reg_addr(ssp_pkg::IDX_BUF): begin
				if (busy) begin
					// [R22] Write ignored, collision flagged.
					next_ctrl[ssp_pkg::CT_WRITE_COLLISION_FLAG] = 1'b1;
				end else begin
					next_buf = wdata_in;
					next_sr = wdata_in;
					next_sdo = wdata_in[7];
					next_mst_run = is_mst;
					next_div = half - 6'h01;
					next_edges = 5'h00;
				end
			end
			ssp_pkg::reg_addr(ssp_pkg::IDX_CTRL): next_ctrl = wdata_in;
			ssp_pkg::reg_addr(ssp_pkg::IDX_DIR): next_dir = wdata_in;
			ssp_pkg::reg_addr(ssp_pkg::IDX_EN):
				next_flag_en = wdata_in[ssp_pkg::FL_PORT];
			ssp_pkg::reg_addr(ssp_pkg::IDX_SADR): begin
				next_sadr = wdata_in;
				next_stat[ssp_pkg::ST_UA] = 1'b0;
			end
			ssp_pkg::reg_addr(ssp_pkg::IDX_STAT): begin
				next_stat[ssp_pkg::ST_SMP] = wdata_in[ssp_pkg::ST_SMP];
				next_stat[ssp_pkg::ST_CKE] = wdata_in[ssp_pkg::ST_CKE];
			end
			default: next_ctrl = next_ctrl;
			endcase
		end

		// Master clock generator; a sleeping master holds every count.
		if (!mst_run) begin
			next_sck = clock_polarity_bit;
		end else if (!sleep_in) begin
			if (div != 6'h00) begin
				next_div = div - 6'h01;
			end else begin
				next_div = half - 6'h01;
				if (edges != ssp_pkg::EDGES_PER_BYTE) begin
					next_sck = ~sck_int;
					next_edges = edges + 5'h01;
				end else if (!pend) begin
					next_mst_run = 1'b0;
				end
			end
		end

		// [R24] Most significant bit leaves first.
		if (out_ev) begin
			next_sdo = take ? sr[6] : sr[7];
		end
		if (take) begin
			next_sr = {sr[6:0], rx_bit};
			next_cnt = cnt + 4'h1;
			next_pend = 1'b0;
			if (cnt == ssp_pkg::BIT_LAST) begin
				// [R21] Byte complete.
				next_cnt = 4'h0;
				next_flag = 1'b1;
				if (stat[ssp_pkg::ST_BF]) begin
					next_ctrl[ssp_pkg::CT_OV] = 1'b1;
				end else begin
					next_buf = {sr[6:0], rx_bit};
					next_stat[ssp_pkg::ST_BF] = 1'b1;
				end
			end
		end
		if (samp_ev & is_mst & sample_phase_bit) begin
			next_pend = 1'b1;
		end
		// [R4] Select high clears count.
		if (is_slv & ss_ctl & syn[2]) begin
			next_cnt = 4'h0;
		end

		// [R12] Start and stop conditions.
		if (i2c_slv | i2c_ssi) begin
			if (start) begin
				next_stat[ssp_pkg::ST_S] = 1'b1;
				next_stat[ssp_pkg::ST_P] = 1'b0;
				next_flag = next_flag | i2c_ssi;
				next_ist = i2c_slv ? ssp_pkg::I_RX : ssp_pkg::I_IDLE;
				next_cnt = 4'h0;
				next_ack = 1'b0;
				next_addr_ph = 1'b1;
				next_addr2 = 1'b0;
			end else if (stop) begin
				next_stat[ssp_pkg::ST_P] = 1'b1;
				next_stat[ssp_pkg::ST_S] = 1'b0;
				next_flag = next_flag | i2c_ssi;
				next_ist = ssp_pkg::I_IDLE;
				next_cnt = 4'h0;
				next_ack = 1'b0;
			end else begin
				case (ist)
				ssp_pkg::I_RX: begin
					if (rise && cnt != ssp_pkg::I2C_BITS) begin
						next_sr = {sr[6:0], syn[1]};
						next_cnt = cnt + 4'h1;
					end
					if (fall && cnt == ssp_pkg::I2C_BITS) begin
						if (addr_ph && !i2c_match) begin
							next_ist = ssp_pkg::I_IDLE;
							next_cnt = 4'h0;
						end else begin
							next_ist = ssp_pkg::I_ACK;
							next_flag = 1'b1;
							next_stat[ssp_pkg::ST_DA] = ~addr_ph;
							if (addr_ph) begin
								next_stat[ssp_pkg::ST_UA] = ten;
								if (!addr2) begin
									next_rw = sr[0];
									next_stat[ssp_pkg::ST_RW] = sr[0];
								end
								next_addr2 = ten & ~addr2 & ~sr[0];
								next_addr_ph = ten & ~addr2 & ~sr[0];
							end
							if (stat[ssp_pkg::ST_BF] | ctrl[ssp_pkg::CT_OV]) begin
								// [R19] Withhold ack and load.
								next_ack = 1'b0;
								if (stat[ssp_pkg::ST_BF]) begin
									next_ctrl[ssp_pkg::CT_OV] = 1'b1;
								end
							end else begin
								// [R18] Acknowledge, then load.
								next_ack = 1'b1;
								next_buf = sr;
								next_stat[ssp_pkg::ST_BF] = 1'b1;
							end
						end
					end
				end
				ssp_pkg::I_ACK: begin
					if (fall) begin
						next_ack = 1'b0;
						next_cnt = 4'h0;
						next_ist = (rw && !addr_ph) ? ssp_pkg::I_TX
							: ssp_pkg::I_RX;
					end
				end
				ssp_pkg::I_TX: begin
					if (fall) begin
						if (cnt == ssp_pkg::BIT_LAST) begin
							next_ist = ssp_pkg::I_TXACK;
							next_cnt = 4'h0;
						end else begin
							next_sr = {sr[6:0], 1'b0};
							next_cnt = cnt + 4'h1;
						end
					end
				end
				ssp_pkg::I_TXACK: begin
					if (rise) begin
						next_flag = 1'b1;
						if (syn[1]) begin
							next_ist = ssp_pkg::I_IDLE;
						end
					end else if (fall) begin
						next_ist = ssp_pkg::I_TX;
					end
				end
				default: next_ist = ssp_pkg::I_IDLE;
				endcase
			end
		end else begin
			next_ist = ssp_pkg::I_IDLE;
		end

		// [R4] Disabled port aborts and clears count.
		if (!en) begin
			next_cnt = 4'h0;
			next_mst_run = 1'b0;
			next_pend = 1'b0;
			next_ack = 1'b0;
			next_ist = ssp_pkg::I_IDLE;
		end
	end

	// [R9] Reset clears the enable and aborts any transfer.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ctrl <= ssp_pkg::CTRL_RST;
			stat <= ssp_pkg::STAT_RST;
			buf_q <= ssp_pkg::BUF_RST;
			sadr <= ssp_pkg::SADR_RST;
			dir <= ssp_pkg::DIR_RST;
			rdata <= 8'h00;
			flag <= ssp_pkg::FLAG_RST;
			flag_en <= ssp_pkg::EN_RST;
			sr <= 8'h00;
			sdo_q <= 1'b0;
			cnt <= 4'h0;
			mst_run <= 1'b0;
			div <= 6'h00;
			sck_int <= 1'b0;
			edges <= 5'h00;
			pend <= 1'b0;
			ist <= ssp_pkg::I_IDLE;
			ack <= 1'b0;
			rw <= 1'b0;
			addr_ph <= 1'b0;
			addr2 <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			stat <= next_stat;
			buf_q <= next_buf;
			sadr <= next_sadr;
			dir <= next_dir;
			rdata <= next_rdata;
			flag <= next_flag;
			flag_en <= next_flag_en;
			sr <= next_sr;
			sdo_q <= next_sdo;
			cnt <= next_cnt;
			mst_run <= next_mst_run;
			div <= next_div;
			sck_int <= next_sck;
			edges <= next_edges;
			pend <= next_pend;
			ist <= next_ist;
			ack <= next_ack;
			rw <= next_rw;
			addr_ph <= next_addr_ph;
			addr2 <= next_addr2;
		end
	end

	assign rdata_out = rdata;
	assign sck_out = sck_int;
	assign sdo_out = sdo_q;
	// The data pin is open-drain, so it only ever pulls low.
	assign sda_out = 1'b0;
	assign sck_oe_out = is_mst & ~dir[ssp_pkg::DIR_SCK];
	// [R3] Select high releases output.
	// [R6] Direction bit as input blocks output.
	assign sdo_oe_out = (is_mst | slv_act) & ~dir[ssp_pkg::DIR_SDO];
	// [R16] Open-drain only with both pins as inputs.
	// [R17] Transmitter drives its data bits.
	assign sda_oe_out = i2c_slv & dir[ssp_pkg::DIR_SDA]
		& dir[ssp_pkg::DIR_SCK]
		& (((ist == ssp_pkg::I_ACK) & ack)
		| ((ist == ssp_pkg::I_TX) & ~sr[7]));
	// [R8] Flag wakes a sleeping device when enabled.
	assign wake_out = flag & flag_en;
endmodule

// file: test/ssp_top_assertions.sv
`timescale 1ns/100ps
module ssp_top_assertions (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Register port
	input wire logic [ssp_pkg::ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic [7:0] rdata_out,
	// Pins
	input wire logic sck_oe_out,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic sdo_oe_out,
	input wire logic ss_n_in,
	input wire logic wake_out
);
	logic [7:0] ctrl, dir, ien, next_ctrl, next_dir, next_ien;
	logic act, slv, i2c;
	// Only software writes these fields, so a shadow taken off the bus is
	// exact; hardware-set flag bits are never used here.
	always_comb begin
		next_ctrl = ctrl;
		next_dir = dir;
		next_ien = ien;
		if (wr_in && addr_in == 10'h050) begin
			next_ctrl = wdata_in;
		end
		if (wr_in && addr_in == 10'h21C) begin
			next_dir = wdata_in;
		end
		if (wr_in && addr_in == 10'h230) begin
			next_ien = wdata_in;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ctrl <= 8'h00;
			dir <= 8'h07;
			ien <= 8'h00;
		end else begin
			ctrl <= next_ctrl;
			dir <= next_dir;
			ien <= next_ien;
		end
	end
	assign act = ctrl[5];
	assign slv = act && ctrl[3:0] == 4'h4 && !dir[0];
	assign i2c = act && ctrl[2:1] == 2'b11;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	// Four samples let the select level cross the synchroniser.
	sequence s_sel(lvl);
		(slv && ss_n_in == lvl) [*4];
	endsequence
	a_sel_drive: assert property (s_sel(1'b0) |-> sdo_oe_out)
		else $error("serial output not driven while selected");
	a_sel_float: assert property (s_sel(1'b1) |-> !sdo_oe_out)
		else $error("serial output driven while deselected");
	a_dir_off: assert property (dir[0] |-> !sdo_oe_out)
		else $error("serial output driven while set as input");
	a_off_quiet: assert property (!act |-> !sdo_oe_out && !sda_oe_out)
		else $error("pins driven while port disabled");
	a_wake_en: assert property (wake_out |-> ien[3])
		else $error("wake without interrupt enable");
	a_sda_gate: assert property (sda_oe_out |-> i2c && dir[2:1] == 2'b11)
		else $error("data line pulled outside two-wire mode");
	a_sda_low: assert property (sda_out == 1'b0)
		else $error("open-drain data output not low");
	a_sck_gate: assert property (sck_oe_out |-> ctrl[3:0] < 4'h4 && !dir[1])
		else $error("clock pin driven outside master mode");
	a_reset_quiet: assert property ($past(srst_in) |-> rdata_out == 8'h00 && !sdo_oe_out && !wake_out)
		else $error("outputs active right after reset");
endmodule
bind ssp_top ssp_top_assertions chk (
	.clk_sys_in(clk_sys_in), .srst_in(srst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rdata_out(rdata_out),
	.sck_oe_out(sck_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
	.sdo_oe_out(sdo_oe_out), .ss_n_in(ss_n_in), .wake_out(wake_out)
);

// file: test/ssp_spi_master_model.sv
`timescale 1ns/100ps
module ssp_spi_master_model (
	// Lines seen on the bus
	input wire logic sdo_in,
	input wire logic sda_in,
	// Lines driven by the master
	output logic sck_out,
	output logic sdi_out,
	output logic ss_n_out
);
	initial begin
		sck_out = 1'b0;
		sdi_out = 1'b1;
		ss_n_out = 1'b1;
	end
	task automatic idle(input logic p);
		sck_out = p;
	endtask
	task automatic xfer(input logic p, e, input logic [7:0] tx, input int n,
		input logic sel, output logic [7:0] rx);
		rx = 8'h00;
		ss_n_out = !sel;
		#40;
		for (int i = 0; i < n; i++) begin
			if (e) sdi_out = tx[7 - i];
			#40;
			sck_out = !p;
			if (!e) sdi_out = tx[7 - i];
			#40;
			if (e) rx[7 - i] = sdo_in;
			#40;
			sck_out = p;
			#40;
			if (!e) rx[7 - i] = sdo_in;
		end
		#80;
		ss_n_out = 1'b1;
		// A released line shows the inverse so stale data never passes.
		sdi_out = !sdi_out;
	endtask
	task automatic i2c_start();
		sdi_out = 1'b1;
		sck_out = 1'b1;
		#160 sdi_out = 1'b0;
		#80 sck_out = 1'b0;
		#40;
	endtask
	task automatic i2c_byte(input logic [7:0] b, output logic ack);
		for (int i = 0; i < 9; i++) begin
			sdi_out = (i < 8) ? b[7 - i] : 1'b1;
			#40 sck_out = 1'b1;
			if (i == 8) ack = !sda_in;
			#80 sck_out = 1'b0;
			#40;
		end
	endtask
	task automatic i2c_stop();
		sdi_out = 1'b0;
		#40 sck_out = 1'b1;
		#80 sdi_out = 1'b1;
		#80;
	endtask
endmodule

// file: test/tb_ssp_top.sv
`timescale 1ns/100ps
module tb_ssp_top;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic [ssp_pkg::ADDR_W-1:0] addr_in = 10'h000;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic sleep_in = 1'b0;
	logic [7:0] rdata_out;
	logic sck_out, sck_oe_out, sda_out, sda_oe_out, sdo_out, sdo_oe_out;
	logic wake_out, m_sck, m_sdi, ss_n, sck_w, sdi_w, sdo_w;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	logic lpbk = 1'b0;
	localparam logic [9:0] A_FL = 10'h030;
	localparam logic [9:0] A_BUF = 10'h04C;
	localparam logic [9:0] A_CT = 10'h050;
	localparam logic [9:0] A_DIR = 10'h21C;
	localparam logic [9:0] A_ST = 10'h250;
	always #10 clk_sys_in = ~clk_sys_in;
	// The data line has a pull-up; a released serial output shows the inverse.
	assign sck_w = sck_oe_out ? sck_out : m_sck;
	assign sdi_w = sda_oe_out ? 1'b0 : (lpbk ? sdo_w : m_sdi);
	assign sdo_w = sdo_oe_out ? sdo_out : ~sdo_out;
	ssp_spi_master_model mdl (.sdo_in(sdo_w), .sda_in(sdi_w),
		.sck_out(m_sck), .sdi_out(m_sdi), .ss_n_out(ss_n));
	ssp_top dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .sck_in(sck_w), .sck_out(sck_out),
		.sck_oe_out(sck_oe_out), .sdi_in(sdi_w), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
		.ss_n_in(ss_n), .sleep_in(sleep_in), .wake_out(wake_out));
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [9:0] a,
		input logic [7:0] m, e);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1;
		chk(n, e, rdata_out & m);
	endtask
	task automatic end_sim();
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		logic [7:0] rx, k;
		logic ack;
		logic [1:0] md [4];
		md = '{2'b01, 2'b00, 2'b11, 2'b10};
		repeat (10) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		rchk("ctrl", A_CT, 8'hFF, 8'h00);
		rchk("stat", A_ST, 8'hFF, 8'h00);
		rchk("dir", A_DIR, 8'hFF, 8'h07);
		rchk("en", 10'h230, 8'hFF, 8'h00);
		rchk("flags", A_FL, 8'hFF, 8'h00);
		rchk("unmapped", 10'h3F0, 8'hFF, 8'h00);
		wr(A_DIR, 8'h06);
		wr(10'h230, 8'h08);
		// Standard modes 0,0 0,1 1,0 1,1 as {polarity, edge}.
		for (int i = 0; i < 4; i++) begin
			k = 8'(i);
			wr(A_ST, {1'b0, md[i][0], 6'h00});
			wr(A_CT, {3'b001, md[i][1], 4'h4});
			mdl.idle(md[i][1]);
			wr(A_BUF, 8'hA5 ^ k);
			sleep_in <= k[0];
			mdl.xfer(md[i][1], md[i][0], 8'h3C + k, 8, 1'b1, rx);
			repeat (4) @(posedge clk_sys_in);
			chk("wake", 8'h01, {7'h00, wake_out});
			chk("sdo byte", 8'hA5 ^ k, rx);
			rchk("bf", A_ST, 8'h01, 8'h01);
			rchk("buf", A_BUF, 8'hFF, 8'h3C + k);
			rchk("bf clr", A_ST, 8'h01, 8'h00);
			wr(A_FL, 8'h00);
			sleep_in <= 1'b0;
		end
		mdl.xfer(1'b1, 1'b0, 8'h11, 8, 1'b1, rx);
		mdl.xfer(1'b1, 1'b0, 8'h22, 8, 1'b1, rx);
		rchk("ov set", A_CT, 8'h40, 8'h40);
		rchk("no load", A_BUF, 8'hFF, 8'h11);
		rchk("ov held", A_CT, 8'h40, 8'h40);
		wr(A_CT, 8'h34);
		rchk("ov clr", A_CT, 8'h40, 8'h00);
		fork
			mdl.xfer(1'b1, 1'b0, 8'hF0, 3, 1'b1, rx);
			begin
				repeat (20) @(posedge clk_sys_in);
				wr(A_BUF, 8'h77);
			end
		join
		rchk("write_collision_flag", A_CT, 8'h80, 8'h80);
		wr(A_CT, 8'h34);
		mdl.xfer(1'b1, 1'b0, 8'h96, 8, 1'b1, rx);
		rchk("abort", A_BUF, 8'hFF, 8'h96);
		wr(A_CT, 8'h35);
		mdl.xfer(1'b1, 1'b0, 8'hF0, 4, 1'b0, rx);
		wr(A_CT, 8'h15);
		wr(A_CT, 8'h35);
		mdl.xfer(1'b1, 1'b0, 8'h5A, 8, 1'b0, rx);
		rchk("no select", A_BUF, 8'hFF, 8'h5A);
		wr(A_DIR, 8'h07);
		wr(A_CT, 8'h34);
		mdl.xfer(1'b1, 1'b0, 8'hC3, 8, 1'b1, rx);
		rchk("rx only", A_BUF, 8'hFF, 8'hC3);
		wr(A_FL, 8'h00);
		wr(A_DIR, 8'h04);
		wr(A_CT, 8'h20);
		sleep_in <= 1'b1;
		wr(A_BUF, 8'h81);
		repeat (80) @(posedge clk_sys_in);
		rchk("frozen", A_FL, 8'h08, 8'h00);
		sleep_in <= 1'b0;
		repeat (80) @(posedge clk_sys_in);
		rchk("resumed", A_FL, 8'h08, 8'h08);
		rchk("m bf", A_ST, 8'h01, 8'h01);
		rchk("m buf", A_BUF, 8'hFF, 8'h00);
		chk("sck idle", 8'h00, {7'h00, sck_out});
		// Looped back, only the late sample point sees each bit after sync.
		wr(A_ST, 8'h80);
		lpbk <= 1'b1;
		wr(A_BUF, 8'h6B);
		repeat (60) @(posedge clk_sys_in);
		rchk("late sample", A_BUF, 8'hFF, 8'h6B);
		lpbk <= 1'b0;
		wr(A_CT, 8'h00);
		wr(A_FL, 8'h00);
		wr(A_DIR, 8'h07);
		wr(10'h24C, 8'h52);
		wr(A_CT, 8'h26);
		mdl.i2c_start();
		mdl.i2c_byte(8'h52, ack);
		chk("addr ack", 8'h01, {7'h00, ack});
		mdl.i2c_byte(8'h11, ack);
		chk("full nack", 8'h00, {7'h00, ack});
		mdl.i2c_stop();
		rchk("i2c buf", A_BUF, 8'hFF, 8'h52);
		rchk("i2c ov", A_CT, 8'h40, 8'h40);
		rchk("i2c flag", A_FL, 8'h08, 8'h08);
		rchk("stop", A_ST, 8'h10, 8'h10);
		end_sim();
	end
endmodule
